// *** dv/accel_sample_output_fifo_tb.sv ***
`timescale 1ns/1ns
module accel_sample_output_fifo_tb;
  logic        clk, rst_n, tick, s2a, rchg, trig, fast;
  logic [13:0] xv, yv, zv;
  logic [7:0]  dr_stat, d, setup;
  logic [13:0] v;
  logic        wr, rd, rd_start, rd_valid, ovf, wmk;
  logic [7:0]  wr_addr, wr_data, rd_addr, rd_data;
  logic [5:0]  cnt;
  logic        stick, aslp, act, fgate, trgd, gerr;
  logic [7:0]  md [3] = '{8'h40, 8'h80, 8'hC0};
  int          n_mismatch = 0;
  int          n_compared = 0;

  accel_sample_output_fifo #(.DEPTH(32)) i_dut (
    .core_clk_i(clk), .resetn_i(rst_n), .active_tick_i(tick), .sleep_tick_i(stick),
    .auto_sleep_i(aslp), .rate_change_i(rchg), .standby_to_active_i(s2a),
    .active_i(act), .fifo_gate_i(fgate), .fast_read_i(fast), .trigger_i(trig),
    .x_value_i(xv), .y_value_i(yv), .z_value_i(zv), .data_ready_status_i(dr_stat),
    .wr_i(wr), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .rd_i(rd),
    .rd_start_i(rd_start), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .fifo_setup_o(setup), .fifo_count_o(cnt),
    .overflow_o(ovf), .watermark_o(wmk), .triggered_o(trgd), .gate_error_o(gerr)
  );

  host_port i_host (
    .clk_i(clk), .rd_data_i(rd_data), .rd_valid_i(rd_valid), .wr_o(wr),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data), .rd_o(rd), .rd_start_o(rd_start),
    .rd_addr_o(rd_addr)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  function automatic logic [13:0] val(input int k, input int a);
    return 14'(k * 32'h0000_0155 + a * 32'h0000_11A3 + 32'h0000_2001);
  endfunction : val

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic push(input int k);
    @(negedge clk);
    {xv, yv, zv} = {val(k, 0), val(k, 1), val(k, 2)};
    if (aslp) stick = 1'b1;
    else tick = 1'b1;
    @(negedge clk);
    {tick, stick} = 2'b00;
  endtask : push

  task automatic status(input int c, input logic o, input logic w);
    repeat (4) @(negedge clk);
    check({2'b00, cnt}, 8'(c));
    check({7'h00, ovf}, {7'h00, o});
    check({7'h00, wmk}, {7'h00, w});
  endtask : status

  // Whole-sample burst; a burst from 00h starts with the status byte
  task automatic burst(input logic [7:0] a0, input int k, input int n);
    logic [7:0] b;
    logic [13:0] s;
    int j;
    for (int i = 0; i < n; i++) begin
      i_host.rd_byte(i == 0, a0, b);
      j = i - int'(a0 == 8'h00);
      s = val(k, fast ? j : j / 2);
      if (j < 0) check(b, dr_stat);
      else if (!fast && (j % 2)) check(b & 8'hFC, {s[5:0], 2'b00});
      else check(b, s[13:6]);
    end
  endtask : burst

  task automatic final_report;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : final_report

  initial begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    final_report();
  end

  initial begin
    {rst_n, tick, s2a, rchg, trig, fast} = 6'b000000;
    {stick, aslp, act, fgate} = 4'h0;
    {xv, yv, zv, dr_stat} = {42'h0, 8'h5A};
    repeat (6) @(negedge clk);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    i_host.rd_byte(1'b1, 8'h09, d);
    check(d, 8'h00);
    push(1);
    push(2);
    repeat (3) @(negedge clk);
    burst(8'h00, 2, 7);
    fast = 1'b1;
    burst(8'h01, 2, 3);
    burst(8'h00, 2, 4);
    v = val(2, 1);
    i_host.rd_byte(1'b1, 8'h04, d);
    check(d & 8'hFC, {v[5:0], 2'b00});
    fast = 1'b0;
    $display("test current sample done");

    i_host.wr_reg(8'h09, 8'h42);
    for (int k = 10; k < 13; k++) push(k);
    status(3, 1'b0, 1'b1);
    i_host.rd_byte(1'b1, 8'h02, d);
    check(d, 8'h00);
    burst(8'h01, 10, 6);
    status(2, 1'b0, 1'b1);
    i_host.rd_byte(1'b1, 8'h01, d);
    v = val(11, 0);
    check(d, v[13:6]);
    burst(8'h01, 12, 6);
    status(0, 1'b0, 1'b0);
    $display("test fifo read order done");

    for (int f = 0; f < 2; f++) begin
      push(20);
      push(21);
      status(2, 1'b0, 1'b1);
      @(negedge clk);
      {s2a, rchg} = f ? 2'b01 : 2'b10;
      @(negedge clk);
      {s2a, rchg} = 2'b00;
      status(0, 1'b0, 1'b0);
    end
    $display("test flush done");

    // Watermark zero here, so the flag must stay low even when full
    for (int m = 0; m < 3; m++) begin
      i_host.wr_reg(8'h09, 8'h00);
      i_host.wr_reg(8'h09, md[m]);
      @(negedge clk);
      trig = (m == 2);
      @(negedge clk);
      trig = 1'b0;
      for (int k = 30; k < 63; k++) push(k);
      status(32, 1'b1, 1'b0);
      i_host.wr_reg(8'h09, md[(m + 1) % 3]);
      i_host.rd_byte(1'b1, 8'h09, d);
      check(d, md[m]);
      check(setup, md[m]);
      burst(8'h01, (m == 0) ? 31 : 30, 6);
      i_host.wr_reg(8'h09, 8'h00);
      status(0, 1'b0, 1'b0);
    end
    $display("test overflow modes done");

    // Watermark refused while active, mode still taken
    act = 1'b1;
    i_host.wr_reg(8'h09, 8'hC3);
    check(setup, 8'hC0);
    act = 1'b0;
    i_host.wr_reg(8'h09, 8'hC3);
    check(setup, 8'hC3);
    for (int k = 40; k < 45; k++) push(k);
    status(3, 1'b0, 1'b1);
    @(negedge clk);
    trig = 1'b1;
    @(negedge clk);
    trig = 1'b0;
    @(negedge clk);
    check({7'h00, trgd}, 8'h01);
    burst(8'h01, 42, 6);
    i_host.wr_reg(8'h09, 8'h00);
    status(0, 1'b0, 1'b0);
    check({7'h00, trgd}, 8'h00);
    $display("test trigger window done");

    // Gated sleep entry keeps the samples and halts loading until drained
    i_host.wr_reg(8'h09, 8'h40);
    push(50);
    push(51);
    @(negedge clk);
    {aslp, fgate, rchg} = 3'b111;
    @(negedge clk);
    rchg = 1'b0;
    push(52);
    status(2, 1'b0, 1'b0);
    check({7'h00, gerr}, 8'h01);
    burst(8'h01, 50, 6);
    burst(8'h01, 51, 6);
    status(0, 1'b0, 1'b0);
    check({7'h00, gerr}, 8'h00);
    push(53);
    @(negedge clk);
    tick = 1'b1;
    @(negedge clk);
    tick = 1'b0;
    status(1, 1'b0, 1'b0);
    burst(8'h01, 53, 6);
    {aslp, fgate} = 2'b00;
    i_host.wr_reg(8'h09, 8'h00);
    $display("test sleep gate done");
    final_report();
  end
endmodule : accel_sample_output_fifo_tb

// *** dv/host_port.sv ***
`timescale 1ns/1ns
// Host side of the register port; it changes its lines on falling edges
module host_port (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       rd_valid_i,
  output logic            wr_o,
  output logic      [7:0] wr_addr_o,
  output logic      [7:0] wr_data_o,
  output logic            rd_o,
  output logic            rd_start_o,
  output logic      [7:0] rd_addr_o
);
  initial begin
    {wr_o, rd_o, rd_start_o} = 3'b000;
    {wr_addr_o, wr_data_o, rd_addr_o} = {8'hA5, 8'h5A, 8'hC3};
  end

  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    {wr_o, wr_addr_o, wr_data_o} = {1'b1, a, d};
    @(negedge clk_i);
    // Idle lines toggle so a stale address is never mistaken for a live one
    {wr_o, wr_addr_o, wr_data_o} = {1'b0, ~a, ~d};
  endtask : wr_reg

  // One byte of a burst; only the first byte carries an address
  task automatic rd_byte(input logic first, input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    {rd_o, rd_start_o} = {1'b1, first};
    rd_addr_o = first ? a : ~rd_addr_o;
    @(negedge clk_i);
    {rd_o, rd_start_o} = 2'b00;
    rd_addr_o = ~rd_addr_o;
    d = (rd_valid_i === 1'b1) ? rd_data_i : 8'hXX;
  endtask : rd_byte
endmodule : host_port

// *** src/accel_fifo_defines.svh ***
`ifndef ACCEL_FIFO_DEFINES_SVH
`define ACCEL_FIFO_DEFINES_SVH

// Register offsets
`define ADDR_STATUS 8'h00
`define ADDR_X_HIGH 8'h01
`define ADDR_X_LOW  8'h02
`define ADDR_Y_HIGH 8'h03
`define ADDR_Y_LOW  8'h04
`define ADDR_Z_HIGH 8'h05
`define ADDR_Z_LOW  8'h06
`define ADDR_PAST_Z 8'h07
`define ADDR_SETUP  8'h09

// Setup register fields and reset
`define SETUP_MODE_MSB 7
`define SETUP_MODE_LSB 6
`define SETUP_WMRK_MSB 5
`define SETUP_WMRK_LSB 0
`define SETUP_RESET    8'h00

// Sample and buffer geometry
`define SAMPLE_BITS 14
`define FIFO_DEPTH  32

`endif

// *** src/accel_fifo_pkg.sv ***
`include "accel_fifo_defines.svh"

package accel_fifo_pkg;

  typedef enum logic [1:0] {
    FIFO_OFF  = 2'b00,
    FIFO_CIRC = 2'b01,
    FIFO_STOP = 2'b10,
    FIFO_TRIG = 2'b11
  } fifo_mode_e;

  typedef logic [3*`SAMPLE_BITS-1:0] triple_t;

endpackage : accel_fifo_pkg

// *** src/accel_sample_output_fifo.sv ***
`timescale 1ns/1ns
`include "accel_fifo_defines.svh"
module accel_sample_output_fifo #(
  parameter int DEPTH = `FIFO_DEPTH
) (
  input  wire logic        core_clk_i,
  input  wire logic        resetn_i,
  input  wire logic        active_tick_i,
  input  wire logic        sleep_tick_i,
  input  wire logic        auto_sleep_i,
  input  wire logic        rate_change_i,
  input  wire logic        standby_to_active_i,
  input  wire logic        active_i,
  input  wire logic        fifo_gate_i,
  input  wire logic        fast_read_i,
  input  wire logic        trigger_i,
  input  wire logic [13:0] x_value_i,
  input  wire logic [13:0] y_value_i,
  input  wire logic [13:0] z_value_i,
  input  wire logic [7:0]  data_ready_status_i,
  input  wire logic        wr_i,
  input  wire logic [7:0]  wr_addr_i,
  input  wire logic [7:0]  wr_data_i,
  input  wire logic        rd_i,
  input  wire logic        rd_start_i,
  input  wire logic [7:0]  rd_addr_i,
  output logic      [7:0]  rd_data_o,
  output logic             rd_valid_o,
  output logic      [7:0]  fifo_setup_o,
  output logic      [5:0]  fifo_count_o,
  output logic             overflow_o,
  output logic             watermark_o,
  output logic             triggered_o,
  output logic             gate_error_o
);

  typedef struct packed {
    accel_fifo_pkg::fifo_mode_e mode;
    logic [5:0]                 wmrk;
    accel_fifo_pkg::triple_t    cur;
    accel_fifo_pkg::triple_t    snap;
    logic [7:0]                 addr;
    logic [7:0]                 rdata;
    logic                       rvalid;
    logic [5:0]                 cnt;
    logic                       ovf;
    logic                       wmf;
    logic                       trig;
    logic                       gate;
  } state_s;

  state_s                  q;
  state_s                  d;
  logic                    rst_meta_q;
  logic                    rst_n;
  logic                    push_c;
  logic                    drop_c;
  logic                    pop_c;
  logic                    flush_c;
  logic                    tick_c;
  logic                    fifo_on;
  logic                    wm_now;
  logic [7:0]              addr_eff;
  logic [1:0]              new_mode;
  accel_fifo_pkg::triple_t src;
  accel_fifo_pkg::triple_t ring_head;
  logic [5:0]              ring_cnt;
  logic                    ring_full;
  logic                    ring_empty;

  // Reset enters asynchronously, leaves synchronously
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  function automatic logic [7:0] next_addr(input logic [7:0] a,
                                           input logic       fast,
                                           input logic       fifo);
    logic [7:0] last;
    last = fast ? `ADDR_Z_HIGH : `ADDR_Z_LOW;
    if (a == `ADDR_STATUS) begin
      next_addr = `ADDR_X_HIGH;
    end else if (a >= last && a <= `ADDR_Z_LOW) begin
      // The FIFO wraps to the next sample's X byte
      next_addr = fifo ? `ADDR_X_HIGH : `ADDR_PAST_Z;
    end else if (fast && a[0] && a < last) begin
      next_addr = a + 8'h02;
    end else begin
      next_addr = a + 8'h01;
    end
  endfunction : next_addr

  sample_ring #(
    .WIDTH (3*`SAMPLE_BITS),
    .DEPTH (DEPTH)
  ) u_ring (
    .clk_i   (core_clk_i),
    .rst_n_i (rst_n),
    .push_i  (push_c),
    .drop_i  (drop_c),
    .pop_i   (pop_c),
    .flush_i (flush_c),
    .data_i  (d.cur),
    .head_o  (ring_head),
    .count_o (ring_cnt),
    .full_o  (ring_full),
    .empty_o (ring_empty)
  );

  assign fifo_on  = (q.mode != accel_fifo_pkg::FIFO_OFF);
  assign addr_eff = rd_start_i ? rd_addr_i : q.addr;
  assign tick_c   = auto_sleep_i ? sleep_tick_i : active_tick_i;
  assign new_mode = wr_data_i[`SETUP_MODE_MSB:`SETUP_MODE_LSB];
  assign wm_now   = fifo_on && (q.wmrk != 6'h00) && (ring_cnt >= q.wmrk);

  always_comb begin
    d       = q;
    push_c  = 1'b0;
    drop_c  = 1'b0;
    pop_c   = 1'b0;
    flush_c = 1'b0;
    src     = q.cur;
    d.rvalid = rd_i;

    // Setup writes; modes cannot jump between one another
    if (wr_i && wr_addr_i == `ADDR_SETUP) begin
      if (new_mode == accel_fifo_pkg::FIFO_OFF || !fifo_on || new_mode == q.mode) begin
        d.mode = accel_fifo_pkg::fifo_mode_e'(new_mode);
      end
      if (!active_i) begin
        d.wmrk = wr_data_i[`SETUP_WMRK_MSB:`SETUP_WMRK_LSB];
      end
    end

    if (tick_c) begin
      d.cur = {x_value_i, y_value_i, z_value_i};
    end

    // Gated sleep entry keeps the contents instead of flushing
    if (rate_change_i && auto_sleep_i && fifo_gate_i && fifo_on) begin
      d.gate = 1'b1;
    end else if (rate_change_i || standby_to_active_i) begin
      flush_c = 1'b1;
    end

    if (q.mode == accel_fifo_pkg::FIFO_TRIG && trigger_i) begin
      d.trig = 1'b1;
    end

    // Loading; the watermark never stops it
    if (fifo_on && tick_c && !q.gate && !flush_c) begin
      case (q.mode)
        accel_fifo_pkg::FIFO_CIRC: begin
          push_c = 1'b1;
          drop_c = ring_full;
        end
        accel_fifo_pkg::FIFO_STOP: begin
          push_c = 1'b1;
        end
        accel_fifo_pkg::FIFO_TRIG: begin
          if (q.trig) begin
            push_c = 1'b1;
          end else begin
            push_c = 1'b1;
            drop_c = ring_full || (q.wmrk != 6'h00 && ring_cnt >= q.wmrk);
          end
        end
        default: begin
          push_c = 1'b0;
        end
      endcase
    end

    // Reads
    if (rd_i) begin
      if (fifo_on && addr_eff == `ADDR_X_HIGH) begin
        src    = ring_empty ? '0 : ring_head;
        pop_c  = !ring_empty;
        d.snap = src;
      end else if (fifo_on) begin
        src = q.snap;
      end
      if (addr_eff == `ADDR_STATUS) begin
        d.rdata = data_ready_status_i;
      end else if (fifo_on && rd_start_i && addr_eff >= `ADDR_X_LOW
                   && addr_eff <= `ADDR_Z_LOW) begin
        d.rdata = 8'h00;
      end else if (addr_eff == `ADDR_X_HIGH) begin
        d.rdata = src[41:34];
      end else if (addr_eff == `ADDR_X_LOW) begin
        d.rdata = {src[33:28], 2'h0};
      end else if (addr_eff == `ADDR_Y_HIGH) begin
        d.rdata = src[27:20];
      end else if (addr_eff == `ADDR_Y_LOW) begin
        d.rdata = {src[19:14], 2'h0};
      end else if (addr_eff == `ADDR_Z_HIGH) begin
        d.rdata = src[13:6];
      end else if (addr_eff == `ADDR_Z_LOW) begin
        d.rdata = {src[5:0], 2'h0};
      end else if (addr_eff == `ADDR_SETUP) begin
        d.rdata = {q.mode, q.wmrk};
      end else begin
        d.rdata = 8'h00;
      end
      d.addr = next_addr(addr_eff, fast_read_i, fifo_on);
    end

    // Count and watermark flag track the ring count one cycle behind; overflow stays set once full
    d.cnt = ring_cnt;
    d.wmf = wm_now;
    if (fifo_on && ring_full) begin
      d.ovf = 1'b1;
    end
    // Host has drained the ring, acquisition may resume
    if (q.gate && ring_empty && !(rate_change_i && auto_sleep_i && fifo_gate_i)) begin
      d.gate = 1'b0;
    end

    // Disabling wins over everything, nothing can arrive meanwhile
    if (d.mode == accel_fifo_pkg::FIFO_OFF) begin
      flush_c = 1'b1;
      push_c  = 1'b0;
      pop_c   = 1'b0;
      d.ovf   = 1'b0;
      d.wmf   = 1'b0;
      d.trig  = 1'b0;
      d.gate  = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign rd_data_o    = q.rdata;
  assign rd_valid_o   = q.rvalid;
  assign fifo_setup_o = {q.mode, q.wmrk};
  assign fifo_count_o = q.cnt;
  assign overflow_o   = q.ovf;
  assign watermark_o  = q.wmf;
  assign triggered_o  = q.trig;
  assign gate_error_o = q.gate;

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n);

  a_disable_clears: assert property (
    (q.mode == accel_fifo_pkg::FIFO_OFF)[*2] |=> !overflow_o && !watermark_o
      && fifo_count_o == 6'h00)
    else $error("disabled fifo left flags or count");

  a_overflow_set: assert property (
    ring_full && d.mode != accel_fifo_pkg::FIFO_OFF |=> overflow_o)
    else $error("overflow flag missed at full count");

  a_wmrk_follow: assert property (
    wm_now && d.mode != accel_fifo_pkg::FIFO_OFF |=> watermark_o)
    else $error("watermark flag not raised");

  a_wmrk_zero: assert property (
    q.wmrk == 6'h00 |=> !watermark_o)
    else $error("watermark flag with zero watermark");

  a_direct_low_zero: assert property (
    rd_i && rd_start_i && fifo_on && d.mode != accel_fifo_pkg::FIFO_OFF
      && rd_addr_i >= `ADDR_X_LOW && rd_addr_i <= `ADDR_Z_LOW
      |=> rd_valid_o && rd_data_o == 8'h00)
    else $error("fifo mode direct low read not zero");

  a_x_high_layout: assert property (
    rd_i && rd_start_i && !fifo_on && rd_addr_i == `ADDR_X_HIGH
      |=> rd_data_o == $past(q.cur[41:34]))
    else $error("x high byte wrong");

  a_low_direct: assert property (
    rd_i && rd_start_i && !fifo_on && rd_addr_i == `ADDR_Y_LOW
      |=> rd_data_o == {$past(q.cur[19:14]), 2'h0})
    else $error("low byte direct read wrong");

  a_fast_skip: assert property (
    rd_i && !rd_start_i && fast_read_i && q.addr == `ADDR_X_HIGH
      |=> q.addr == `ADDR_Y_HIGH)
    else $error("fast read did not skip low byte");

  a_mode_lock: assert property (
    wr_i && wr_addr_i == `ADDR_SETUP && fifo_on
      && new_mode != 2'h0 && new_mode != q.mode |=> $stable(q.mode))
    else $error("mode switched between operating modes");

  a_pop_head: assert property (
    pop_c && !push_c && !flush_c |=> ring_cnt == $past(ring_cnt) - 6'h01)
    else $error("fifo read did not drop count by one");

  a_gate_halts: assert property (
    q.gate |-> !push_c)
    else $error("gated fifo accepted a sample");

  a_pretrig_limit: assert property (
    q.mode == accel_fifo_pkg::FIFO_TRIG && !q.trig && q.wmrk != 6'h00
      && ring_cnt >= q.wmrk |=> ring_cnt <= $past(ring_cnt))
    else $error("pre-trigger count grew past watermark");

  a_sleep_rate: assert property (
    auto_sleep_i && !sleep_tick_i |=> $stable(q.cur))
    else $error("sample taken off the sleep rate");

  a_trig_full_hold: assert property (
    q.trig && ring_full && !pop_c && !flush_c |=> ring_full && $stable(ring_head))
    else $error("triggered full fifo changed its contents");

  c_fifo_burst: cover property (rd_i && pop_c ##2 rd_i ##2 rd_i);
  c_overflow:   cover property ($rose(overflow_o));
  c_trigger:    cover property ($rose(triggered_o) ##[1:200] ring_full);
  c_gate:       cover property ($rose(gate_error_o) ##[1:100] $fell(gate_error_o));

endmodule : accel_sample_output_fifo

// *** src/sample_ring.sv ***
`timescale 1ns/1ns
// Pointers wrap naturally, so DEPTH must be a power of two
module sample_ring #(
  parameter int WIDTH = 42,
  parameter int DEPTH = 32
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             push_i,
  input  wire logic             drop_i,
  input  wire logic             pop_i,
  input  wire logic             flush_i,
  input  wire logic [WIDTH-1:0] data_i,
  output logic      [WIDTH-1:0] head_o,
  output logic      [$clog2(DEPTH+1)-1:0] count_o,
  output logic                  full_o,
  output logic                  empty_o
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               wr;
    logic [AW-1:0]               rd;
    logic [CW-1:0]               cnt;
  } ring_s;

  ring_s q;
  ring_s d;
  logic  do_pop;
  logic  do_drop;
  logic  do_push;

  assign full_o  = (q.cnt == CW'(DEPTH));
  assign empty_o = (q.cnt == '0);
  assign head_o  = q.mem[q.rd];
  assign count_o = q.cnt;

  always_comb begin
    d       = q;
    do_pop  = pop_i && !empty_o;
    do_drop = push_i && drop_i && !empty_o && !do_pop;
    do_push = push_i && (!full_o || do_pop || do_drop);
    if (flush_i) begin
      d.wr  = '0;
      d.rd  = '0;
      d.cnt = '0;
    end else begin
      if (do_push) begin
        d.mem[q.wr] = data_i;
        d.wr        = q.wr + 1'b1;
      end
      if (do_pop || do_drop) begin
        d.rd = q.rd + 1'b1;
      end
      if (do_push && !do_pop && !do_drop) begin
        d.cnt = q.cnt + 1'b1;
      end else if (!do_push && do_pop) begin
        d.cnt = q.cnt - 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  a_ring_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    q.cnt <= CW'(DEPTH)) else $error("ring count above depth");
  a_ring_stop: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    full_o && push_i && !drop_i && !pop_i && !flush_i |=> full_o && $stable(q.wr))
    else $error("full ring accepted a sample");

endmodule : sample_ring
